// ===== design/sofm_pkg.sv
// Purpose: shared constants and types of the safety output manager
// Assumes: 25 MHz device clock
// Notes: offsets of the host port are local choices
package sofm_pkg;
  // ==========================================
  // register port
  // ==========================================
  localparam logic [3:0] ADDR_CTRL = 4'h0; // power mode control
  localparam logic [3:0] ADDR_INCFG = 4'h1; // error input config
  localparam logic [3:0] ADDR_WDW = 4'h2; // window config
  localparam logic [3:0] ADDR_REL = 4'h3; // release command
  localparam logic [3:0] ADDR_KEY = 4'h4; // refresh key readback
  localparam logic [3:0] ADDR_STAT = 4'h5; // status readback
  localparam logic [3:0] ADDR_REFRESH = 4'h6; // refresh answer
  // ==========================================
  // release command fields
  // ==========================================
  localparam int REL_SEL_HI = 15; // select field top
  localparam int REL_SEL_LO = 13; // select field bottom
  localparam logic [2:0] REL_FS = 3'h3; // fail-safe only
  localparam logic [2:0] REL_LIMP = 3'h6; // limp only
  localparam logic [2:0] REL_BOTH = 3'h5; // both outputs
  // ==========================================
  // keys and modes
  // ==========================================
  localparam logic [15:0] KEY_FIRST = 16'h5AB2; // key after power-on
  localparam logic [15:0] KEY_SECOND = 16'hD564; // alternate key
  localparam logic [2:0] INCFG_OFF = 3'h0; // monitoring disabled
  localparam logic [2:0] INCFG_PAIR = 3'h1; // bistable pair default
  localparam logic [2:0] INCFG_LVL_PWM = 3'h7; // a level, b pwm
  localparam logic [3:0] WDW_DISABLED = 4'h0; // window off code
  localparam logic [3:0] FLT_CNT_MAX = 4'h6; // counter full level
  localparam logic [3:0] FLT_CNT_RESET = 4'h1; // counter at power-up
  localparam logic [3:0] ERR_LIMIT_RESET = 4'h6; // run limit; a step takes one refresh more
  // ==========================================
  // timing
  // ==========================================
  localparam int CLK_HZ = 25_000_000; // device clock rate
  localparam int PWM_HI_MIN_US = 100; // shortest legal high phase
  localparam int PWM_LO_MAX_US = 1000; // longest legal low phase
  localparam int PWM_HI_MIN_CYC = (PWM_HI_MIN_US * (CLK_HZ / 1000000));
  localparam int PWM_LO_MAX_CYC = (PWM_LO_MAX_US * (CLK_HZ / 1000000));
  localparam int RST_STUCK_S = 8; // reset stuck-low limit
  localparam int RST_STUCK_CYC = RST_STUCK_S * CLK_HZ;
  localparam int REC_UNIT_MS = 1; // recovery window step
  localparam int REC_UNIT_CYC = REC_UNIT_MS * (CLK_HZ / 1000);
  localparam int RST_PULSE_CYC = 25; // reset pulse length
  // power modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_LOW_POWER_ON_MODE = 2'b01,
    MODE_LOW_POWER_OFF_MODE = 2'b11,
    MODE_FAILSAFE = 2'b10
  } power_mode_t;
endpackage : sofm_pkg

// ===== design/err_mon_if.sv
// Purpose: carrier between the manager and one error input monitor
// Assumes: one clock
// Notes: monitor reports a fault level
`timescale 1ns/1ps
interface err_mon_if;
  logic enable; // monitoring active
  logic pwm_mode; // 1 pwm, 0 steady level
  logic fault_pol; // level that means fault
  logic fault; // fault seen
  modport mgr (output enable, output pwm_mode, output fault_pol,
    input fault);
  modport mon (input enable, input pwm_mode, input fault_pol,
    output fault);
endinterface : err_mon_if

// ===== design/err_input_monitor.sv
// Purpose: watches one error input in level or pwm mode
// Assumes: input synchronous to the clock
// Notes: pwm thresholds fixed by parameters
`timescale 1ns/1ps
module err_input_monitor #(
  parameter int HI_MIN = sofm_pkg::PWM_HI_MIN_CYC,
  parameter int LO_MAX = sofm_pkg::PWM_LO_MAX_CYC
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic pin_in,
  err_mon_if.mon mon
);
  // ==========================================
  // phase measurement
  // ==========================================
  logic prev_r; // last pin level
  logic [19:0] phase_r; // phase length counter
  logic fault_r; // latched fault level
  // count cycles of the current phase
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !mon.enable) begin
      prev_r <= 1'b0;
      phase_r <= 20'h0_0000;
    end else begin
      prev_r <= pin_in;
      if (pin_in != prev_r) begin
        phase_r <= 20'h0_0001;
      end else if (phase_r != 20'hF_FFFF) begin
        phase_r <= phase_r + 20'h0_0001;
      end
    end
  end
  // fault decision, level or pwm
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !mon.enable) begin
      fault_r <= 1'b0;
    end else if (!mon.pwm_mode) begin
      fault_r <= (pin_in == mon.fault_pol);
    end else if (prev_r && !pin_in && phase_r < 20'(HI_MIN)) begin
      fault_r <= 1'b1; // high phase too short
    end else if (!pin_in && phase_r > 20'(LO_MAX)) begin
      fault_r <= 1'b1; // low phase too long
    end else if (pin_in && !prev_r) begin
      fault_r <= 1'b0; // good edge clears the pwm fault
    end
  end
  assign mon.fault = fault_r;
endmodule : err_input_monitor

// ===== design/safety_output_fault_manager.sv
// Purpose: drives reset, fail-safe and limp outputs from faults
// Assumes: register port is a simple write/read strobe pair
// Notes: watchdog timing is reduced to refresh strobes
//
// Behaviour
// - two error inputs monitored independently
// - level mode uses per-input polarity
// - pwm: short high or long low faults
// - code 111: a level, b pwm
// - reset line bidirectional, both may hold low
// - reset stuck low too long: fail-safe
// - release only with all conditions met
// - bits 15..13 pick release target
// - single release: inverted reversed token bits
// - combined release: two inverted reversed slices
// - counter steps down per full refresh run
// - valid release drives outputs high
// - period code zero disables watchdog with recovery off
// - recovery code zero disables watchdog with recovery on
// - monitoring starts at init close; zero disables
// - low-power modes stop monitoring
// - standby asserts fail-safe output
// - outputs active low, documented start levels
// - counter full: enter fail-safe state
// - recovery: controller fault opens recovery window
// - good refresh ends recovery if clean
// - recovery timeout: reset pulse, fail-safe
// - key alternates after each good refresh
// - default config is bistable pair
`timescale 1ns/1ps
module safety_output_fault_manager #(
  parameter int RST_STUCK = sofm_pkg::RST_STUCK_CYC,
  parameter int REC_UNIT = sofm_pkg::REC_UNIT_CYC,
  parameter bit RST_STUCK_EN = 1'b1 // one-time config option
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  input wire logic error_in_a,
  input wire logic error_in_b,
  input wire logic reset_line_in,
  output logic reset_line_out,
  output logic reset_line_oe_n_out,
  output logic failsafe_out,
  output logic limp_home_out,
  input wire logic debug_mode_in
);
  // ==========================================
  // state
  // ==========================================
  sofm_pkg::power_mode_t mode_r; // power mode
  logic init_phase_r; // init window open
  logic [2:0] error_input_mode_r; // input config
  logic [1:0] error_in_polarity_r; // per-input polarity
  logic [2:0] impact_r; // fault impact: rst, fs, limp
  logic [3:0] window_period_sel_r; // period code
  logic [3:0] recovery_window_sel_r; // recovery code
  logic recovery_enable_r; // recovery feature on
  logic wd_enabled_r; // watchdog live after init
  logic [15:0] refresh_key_r; // current key
  logic [3:0] fault_error_counter_r; // fault count
  logic [3:0] good_refresh_counter_r; // good refresh run
  logic [3:0] refresh_error_limit_r; // run length
  logic fs_asserted_r; // fail-safe asserted
  logic limp_asserted_r; // limp asserted
  logic rst_asserted_r; // device reset drive
  logic in_recovery_r; // recovery window running
  logic [13:0] rec_ms_r; // ms left in window
  logic [19:0] rec_div_r; // ms divider
  logic [27:0] stuck_r; // reset low counter
  logic [4:0] rst_pulse_r; // reset pulse counter
  logic ctrl_fault, ctrl_fault_q; // any input fault, and last cycle
  logic refresh_ok; // good refresh strobe
  logic rel_wr; // release write strobe
  logic [12:0] exp_fs, exp_limp, exp_both; // expected payloads
  logic rel_allowed; // release preconditions
  logic mon_en; // monitoring active
  err_mon_if mon_a ();
  err_mon_if mon_b ();
  // ==========================================
  // error input monitors
  // ==========================================
  assign mon_en = !init_phase_r && error_input_mode_r != sofm_pkg::INCFG_OFF
    && mode_r == sofm_pkg::MODE_NORMAL;
  assign mon_a.enable = mon_en;
  assign mon_b.enable = mon_en;
  assign mon_a.pwm_mode = 1'b0; // a is level in both codes
  assign mon_b.pwm_mode = (error_input_mode_r == sofm_pkg::INCFG_LVL_PWM);
  // pair mode: low a or high b faults unless flipped
  assign mon_a.fault_pol = error_in_polarity_r[0];
  assign mon_b.fault_pol = (error_input_mode_r == sofm_pkg::INCFG_PAIR) ?
    !error_in_polarity_r[1] : error_in_polarity_r[1];
  err_input_monitor u_mon_a (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(error_in_a),
    .mon(mon_a.mon)
  );
  err_input_monitor u_mon_b (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(error_in_b),
    .mon(mon_b.mon)
  );
  assign ctrl_fault = mon_a.fault || mon_b.fault;
  // ==========================================
  // register writes
  // ==========================================
  assign refresh_ok = reg_wr_in && reg_addr_in == sofm_pkg::ADDR_REFRESH
    && reg_wdata_in == refresh_key_r;
  assign rel_wr = reg_wr_in && reg_addr_in == sofm_pkg::ADDR_REL;
  // init-only configuration; locked once init closes
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      error_input_mode_r <= sofm_pkg::INCFG_PAIR;
      error_in_polarity_r <= 2'b00;
      impact_r <= 3'b110;
      window_period_sel_r <= 4'h1;
      recovery_window_sel_r <= 4'h1;
      recovery_enable_r <= 1'b0;
      refresh_error_limit_r <= sofm_pkg::ERR_LIMIT_RESET;
    end else if (reg_wr_in && init_phase_r) begin
      if (reg_addr_in == sofm_pkg::ADDR_INCFG) begin
        error_input_mode_r <= reg_wdata_in[2:0];
        error_in_polarity_r <= reg_wdata_in[4:3];
        impact_r <= reg_wdata_in[7:5];
      end
      if (reg_addr_in == sofm_pkg::ADDR_WDW) begin
        window_period_sel_r <= reg_wdata_in[3:0];
        recovery_window_sel_r <= reg_wdata_in[7:4];
        recovery_enable_r <= reg_wdata_in[8];
        refresh_error_limit_r <= reg_wdata_in[12:9];
      end
    end
  end
  // init closes on first good refresh; watchdog state fixed then
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      init_phase_r <= 1'b1;
      wd_enabled_r <= 1'b0;
    end else if (init_phase_r && refresh_ok) begin
      init_phase_r <= 1'b0;
      wd_enabled_r <= recovery_enable_r ?
        recovery_window_sel_r != sofm_pkg::WDW_DISABLED :
        window_period_sel_r != sofm_pkg::WDW_DISABLED;
    end
  end
  // power mode requests and fail-safe entries
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mode_r <= sofm_pkg::MODE_NORMAL;
    end else if (fault_error_counter_r == sofm_pkg::FLT_CNT_MAX) begin
      mode_r <= sofm_pkg::MODE_FAILSAFE;
    end else if (RST_STUCK_EN && stuck_r == 28'(RST_STUCK)) begin
      mode_r <= sofm_pkg::MODE_FAILSAFE;
    end else if (in_recovery_r && wd_enabled_r && rec_ms_r == 14'h0000) begin
      mode_r <= sofm_pkg::MODE_FAILSAFE;
    end else if (reg_wr_in && reg_addr_in == sofm_pkg::ADDR_CTRL &&
        mode_r != sofm_pkg::MODE_FAILSAFE) begin
      mode_r <= sofm_pkg::power_mode_t'(reg_wdata_in[1:0]);
    end
  end
  // ==========================================
  // refresh key and counters
  // ==========================================
  // key alternates after each good refresh
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      refresh_key_r <= sofm_pkg::KEY_FIRST;
    end else if (refresh_ok) begin
      refresh_key_r <= (refresh_key_r == sofm_pkg::KEY_FIRST) ?
        sofm_pkg::KEY_SECOND : sofm_pkg::KEY_FIRST;
    end
  end
  // fault counter: up on new fault, down per full refresh run
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      fault_error_counter_r <= sofm_pkg::FLT_CNT_RESET;
      good_refresh_counter_r <= 4'h0;
      ctrl_fault_q <= 1'b0;
    end else begin
      ctrl_fault_q <= ctrl_fault; // edge finder: one count per fault
      if (refresh_ok) begin
        if (good_refresh_counter_r >= refresh_error_limit_r) begin
          good_refresh_counter_r <= 4'h0;
          if (fault_error_counter_r != 4'h0 && !ctrl_fault)
            fault_error_counter_r <= fault_error_counter_r - 4'h1;
        end else begin
          good_refresh_counter_r <= good_refresh_counter_r + 4'h1;
        end
      end
      // set wins: new fault bumps counter even on a refresh
      if (ctrl_fault && !ctrl_fault_q && !in_recovery_r &&
          fault_error_counter_r != sofm_pkg::FLT_CNT_MAX)
        fault_error_counter_r <= fault_error_counter_r + 4'h1;
    end
  end
  // ==========================================
  // recovery window
  // ==========================================
  // open window after controller fault; restart if still faulty
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      in_recovery_r <= 1'b0;
      rec_ms_r <= 14'h0000;
      rec_div_r <= 20'h0_0000;
    end else if (!in_recovery_r) begin
      if (recovery_enable_r && ctrl_fault) begin
        in_recovery_r <= 1'b1;
        rec_ms_r <= 14'd1 << recovery_window_sel_r[3:0];
        rec_div_r <= 20'h0_0000;
      end
    end else if (refresh_ok) begin
      if (!ctrl_fault) begin
        in_recovery_r <= 1'b0; // back to normal period
      end else begin
        rec_ms_r <= 14'd1 << recovery_window_sel_r[3:0];
        rec_div_r <= 20'h0_0000;
      end
    end else if (rec_ms_r == 14'h0000) begin
      in_recovery_r <= 1'b0; // timed out, fail-safe taken when watchdog enabled
    end else if (rec_div_r == 20'(REC_UNIT - 1)) begin
      rec_div_r <= 20'h0_0000;
      rec_ms_r <= rec_ms_r - 14'h0001;
    end else begin
      rec_div_r <= rec_div_r + 20'h0_0001;
    end
  end
  // ==========================================
  // reset line
  // ==========================================
  // count reset line low, device or controller holding it
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || reset_line_in) begin
      stuck_r <= 28'h000_0000;
    end else if (stuck_r != 28'(RST_STUCK)) begin
      stuck_r <= stuck_r + 28'h000_0001;
    end
  end
  // reset pulse on recovery timeout, then held in fail-safe
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rst_pulse_r <= 5'h00;
      rst_asserted_r <= 1'b1; // asserted from power-up
    end else begin
      if (in_recovery_r && wd_enabled_r && rec_ms_r == 14'h0000)
        rst_pulse_r <= 5'(sofm_pkg::RST_PULSE_CYC);
      else if (rst_pulse_r != 5'h00)
        rst_pulse_r <= rst_pulse_r - 5'h01;
      if (mode_r == sofm_pkg::MODE_FAILSAFE ||
          mode_r == sofm_pkg::MODE_LOW_POWER_OFF_MODE)
        rst_asserted_r <= 1'b1;
      else if (mode_r == sofm_pkg::MODE_NORMAL)
        rst_asserted_r <= rst_pulse_r != 5'h00;
      if (ctrl_fault && impact_r[2] && !recovery_enable_r)
        rst_asserted_r <= 1'b1; // fault resets only with recovery off
    end
  end
  // ==========================================
  // release command
  // ==========================================
  // reversed inverted slices of the key
  always_comb begin
    exp_fs = 13'h0000;
    exp_limp = 13'h0000;
    exp_both = 13'h0000;
    for (int i = 0; i <= 12; i++) begin
      exp_fs[12 - i] = !refresh_key_r[i];
      exp_limp[12 - i] = !refresh_key_r[i + 3];
    end
    for (int i = 0; i <= 6; i++)
      exp_both[12 - i] = !refresh_key_r[i];
    for (int i = 10; i <= 15; i++)
      exp_both[15 - i] = !refresh_key_r[i];
  end
  assign rel_allowed = !init_phase_r && !debug_mode_in
    && fault_error_counter_r == 4'h0 && !ctrl_fault
    && mode_r == sofm_pkg::MODE_NORMAL;
  // assert on fault or mode, release on valid command
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      fs_asserted_r <= 1'b1;
      limp_asserted_r <= 1'b0;
    end else if (mode_r != sofm_pkg::MODE_NORMAL) begin
      fs_asserted_r <= 1'b1;
      limp_asserted_r <= mode_r != sofm_pkg::MODE_LOW_POWER_ON_MODE;
    end else if (ctrl_fault) begin
      if (impact_r[1]) fs_asserted_r <= 1'b1;
      if (impact_r[0]) limp_asserted_r <= 1'b1;
    end else if (rel_wr && rel_allowed) begin
      case (reg_wdata_in[sofm_pkg::REL_SEL_HI:sofm_pkg::REL_SEL_LO])
        sofm_pkg::REL_FS: begin
          if (reg_wdata_in[12:0] == exp_fs) fs_asserted_r <= 1'b0;
        end
        sofm_pkg::REL_LIMP: begin
          if (reg_wdata_in[12:0] == exp_limp) limp_asserted_r <= 1'b0;
        end
        sofm_pkg::REL_BOTH: begin
          if (reg_wdata_in[12:0] == exp_both) begin
            fs_asserted_r <= 1'b0;
            limp_asserted_r <= 1'b0;
          end
        end
        default: fs_asserted_r <= fs_asserted_r; // bad selector ignored
      endcase
    end
  end
  // ==========================================
  // outputs and readback
  // ==========================================
  assign failsafe_out = !fs_asserted_r;
  assign limp_home_out = !limp_asserted_r;
  assign reset_line_out = 1'b0; // open drain, only pulls low
  assign reset_line_oe_n_out = !rst_asserted_r;
  // read data registered
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        sofm_pkg::ADDR_KEY: reg_rdata_out <= refresh_key_r;
        sofm_pkg::ADDR_STAT: reg_rdata_out <= {fault_error_counter_r,
          good_refresh_counter_r, in_recovery_r, init_phase_r,
          mon_b.fault, mon_a.fault, mode_r, wd_enabled_r, 1'b0};
        sofm_pkg::ADDR_INCFG: reg_rdata_out <= {8'h00, impact_r,
          error_in_polarity_r, error_input_mode_r};
        default: reg_rdata_out <= 16'h0000;
      endcase
    end
  end
endmodule : safety_output_fault_manager

// ===== test/mcu_model.sv
// Purpose: controller side of the error pins and reset wire
// Assumes: reset wire has a pull-up
// Notes: no fault shown unless the bench asks
`timescale 1ns/1ps
module mcu_model (
  input wire logic reset_oe_n_in,
  input wire logic reset_drv_in,
  input wire logic hold_low_in,
  input wire logic standby_in,
  output logic reset_wire_out,
  output logic err_a_out,
  output logic err_b_out
);
  // ==========================================
  // wire and error pins
  // ==========================================
  // pull-up wins only when neither side pulls low
  assign reset_wire_out = ((!reset_oe_n_in && !reset_drv_in) || hold_low_in)
    ? 1'b0 : 1'b1;
  // pair no-fault levels; standby swaps both to pair fault levels
  assign err_a_out = !standby_in;
  assign err_b_out = standby_in;
endmodule : mcu_model

// ===== test/sofm_asserts.sv
// Purpose: port checks of the safety output manager
// Assumes: sync active-high reset
// Notes: attached by bind at the foot
`timescale 1ns/1ps
module sofm_asserts #(
  parameter int RST_STUCK = 50
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic error_in_a,
  input wire logic error_in_b,
  input wire logic reset_line_in,
  input wire logic reset_line_out,
  input wire logic reset_line_oe_n_out,
  input wire logic failsafe_out,
  input wire logic limp_home_out,
  input wire logic debug_mode_in
);
  // ==========================================
  // helper logic
  // ==========================================
  int unsigned low_cnt_r; // cycles wire low, saturating
  logic fs_req_r; // last cycle held a fail-safe release
  logic limp_req_r; // last cycle held a limp release
  logic rel_wr; // release write this cycle
  assign rel_wr = reg_wr_in && reg_addr_in == sofm_pkg::ADDR_REL;
  // counter stops early so it never wraps
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || reset_line_in) begin
      low_cnt_r <= 0;
    end else if (low_cnt_r < RST_STUCK + 8) begin
      low_cnt_r <= low_cnt_r + 1;
    end
  end
  // remember release selectors for one cycle
  always_ff @(posedge sys_clk_in) begin
    fs_req_r <= rel_wr && reg_wdata_in[15:13] inside
      {sofm_pkg::REL_FS, sofm_pkg::REL_BOTH};
    limp_req_r <= rel_wr && reg_wdata_in[15:13] inside
      {sofm_pkg::REL_LIMP, sofm_pkg::REL_BOTH};
  end
  // ==========================================
  // properties
  // ==========================================
  default clocking @(posedge sys_clk_in); endclocking
  sequence s_rel_dbg;
    rel_wr ##0 (debug_mode_in && !failsafe_out);
  endsequence
  sequence s_low_power_on_mode_wr;
    reg_wr_in && reg_addr_in == sofm_pkg::ADDR_CTRL &&
      reg_wdata_in[1:0] == 2'h1;
  endsequence
  chk_reset_levels: assert property (srst_in |=>
    !failsafe_out && limp_home_out && !reset_line_oe_n_out)
    else $error("outputs not at reset levels");
  chk_wire_drive: assert property (reset_line_out == 1'b0)
    else $error("reset wire driven high");
  chk_fs_cause: assert property (disable iff (srst_in)
    $rose(failsafe_out) |-> fs_req_r)
    else $error("fail-safe released without command");
  chk_limp_cause: assert property (disable iff (srst_in)
    $rose(limp_home_out) |-> limp_req_r)
    else $error("limp released without command");
  chk_debug_hold: assert property (disable iff (srst_in)
    s_rel_dbg |=> !failsafe_out)
    else $error("release taken in debug mode");
  chk_stuck_fs: assert property (disable iff (srst_in)
    low_cnt_r > RST_STUCK + 4 |-> !failsafe_out && !limp_home_out)
    else $error("stuck reset wire left safety outputs released");
  chk_low_power_on_mode_fs: assert property (disable iff (srst_in)
    s_low_power_on_mode_wr |-> ##[1:2] !failsafe_out)
    else $error("standby left fail-safe released");
  chk_rdata_hold: assert property (disable iff (srst_in)
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
endmodule : sofm_asserts

bind safety_output_fault_manager sofm_asserts #(.RST_STUCK(RST_STUCK)) chk_u (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .error_in_a(error_in_a), .error_in_b(error_in_b),
  .reset_line_in(reset_line_in), .reset_line_out(reset_line_out),
  .reset_line_oe_n_out(reset_line_oe_n_out), .failsafe_out(failsafe_out),
  .limp_home_out(limp_home_out), .debug_mode_in(debug_mode_in));

// ===== test/safety_output_fault_manager_bench.sv
// Purpose: self-checking bench of the safety output manager
// Assumes: 25 MHz clock, short stuck and recovery counts
// Notes: release attempts are table rows
`timescale 1ns/1ps
module safety_output_fault_manager_bench;
  typedef struct packed {
    logic dbg; logic [2:0] sel; logic bad; logic exp_fs;
  } rel_row_t; // one release attempt
  rel_row_t rows [6] = '{'{1'b1, sofm_pkg::REL_FS, 1'b0, 1'b0},
    '{1'b0, 3'h0, 1'b0, 1'b0}, '{1'b0, sofm_pkg::REL_FS, 1'b1, 1'b0},
    '{1'b0, sofm_pkg::REL_LIMP, 1'b0, 1'b0},
    '{1'b0, sofm_pkg::REL_BOTH, 1'b1, 1'b0},
    '{1'b0, sofm_pkg::REL_FS, 1'b0, 1'b1}};
  logic sys_clk_in = 1'b0, srst_in = 1'b1, reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0, debug_mode_in = 1'b0, hold_low = 1'b0;
  logic standby = 1'b0; // partner in pair fault levels
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000, rd_v, key_exp;
  wire [15:0] reg_rdata_out;
  wire err_a, err_b, wire_lvl, drv, oe_n, fs, limp;
  int failures = 0, total_checks = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  // ==========================================
  // design and partner
  // ==========================================
  safety_output_fault_manager #(.RST_STUCK(50), .REC_UNIT(4)) dut_u (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .error_in_a(err_a), .error_in_b(err_b), .reset_line_in(wire_lvl),
    .reset_line_out(drv), .reset_line_oe_n_out(oe_n),
    .failsafe_out(fs), .limp_home_out(limp), .debug_mode_in(debug_mode_in));
  mcu_model mcu_u (.reset_oe_n_in(oe_n), .reset_drv_in(drv),
    .hold_low_in(hold_low), .standby_in(standby), .reset_wire_out(wire_lvl),
    .err_a_out(err_a), .err_b_out(err_b));
  // ==========================================
  // tasks
  // ==========================================
  task check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // strobe for one cycle, then let its effect land
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge sys_clk_in); #1;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1; reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge sys_clk_in); #1 rd_v = reg_rdata_out;
  endtask : rd
  // inverted key bits, reversed, per selector
  function automatic logic [15:0] rel_word(logic [2:0] s, logic [15:0] k);
    logic [15:0] w;
    w = {s, 13'h0000};
    for (int i = 0; i < 13; i++) begin
      if (s == sofm_pkg::REL_BOTH) w[12-i] = ~k[(i < 7) ? i : i + 3];
      else w[12-i] = ~k[(s == sofm_pkg::REL_FS) ? i : i + 3];
    end
    return w;
  endfunction : rel_word
  task give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    failures++;
    give_verdict();
  end
  // ==========================================
  // main sequence
  // ==========================================
  initial begin
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(posedge sys_clk_in); #1;
    check("start levels", {fs, limp, oe_n}, 16'h0003);
    rd(sofm_pkg::ADDR_KEY);
    check("first key", rd_v, sofm_pkg::KEY_FIRST);
    rd(sofm_pkg::ADDR_STAT);
    check("start count", rd_v[15:12], sofm_pkg::FLT_CNT_RESET);
    key_exp = sofm_pkg::KEY_FIRST;
    // limit times count plus one good refreshes clears the counter
    repeat (7) begin
      wr(sofm_pkg::ADDR_REFRESH, key_exp);
      key_exp = (key_exp == sofm_pkg::KEY_FIRST) ? sofm_pkg::KEY_SECOND
        : sofm_pkg::KEY_FIRST;
    end
    rd(sofm_pkg::ADDR_STAT);
    check("count and init", {rd_v[15:12], rd_v[6]}, 16'h0000);
    rd(sofm_pkg::ADDR_KEY);
    check("alternate key", rd_v, key_exp);
    foreach (rows[i]) begin
      @(posedge sys_clk_in);
      debug_mode_in <= rows[i].dbg;
      wr(sofm_pkg::ADDR_REL,
        rel_word(rows[i].sel, key_exp) ^ {15'h0000, rows[i].bad});
      check("release", {fs, limp}, {rows[i].exp_fs, 1'b1});
    end
    // standby: partner shows pair fault levels, counter bumps, fail-safe drops
    standby <= 1'b1;
    wr(sofm_pkg::ADDR_CTRL, 16'h0001);
    check("standby fs", fs, 1'b0);
    rd(sofm_pkg::ADDR_STAT);
    check("standby mode", {rd_v[15:12], rd_v[3:2]}, 16'h0005);
    // second reset mid-run
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    standby <= 1'b0;
    @(posedge sys_clk_in); #1;
    check("rerun levels", {fs, limp, oe_n}, 16'h0003);
    rd(sofm_pkg::ADDR_KEY);
    check("rerun key", rd_v, sofm_pkg::KEY_FIRST);
    // controller holds the wire past the stuck limit
    hold_low <= 1'b1;
    repeat (60) @(posedge sys_clk_in);
    hold_low <= 1'b0;
    #1 check("stuck fs", {fs, limp, oe_n}, 16'h0000);
    give_verdict();
  end
endmodule : safety_output_fault_manager_bench
